// *** logic/loader_pkg.sv ***
// Constants for the power-up configuration loader.
// Assumes one 20 MHz clock and a synchronous active-high reset.
`default_nettype none
package loader_pkg;

	// Store geometry
	localparam int        NV_WORDS    = 256;
	localparam int        WORK_COUNT  = 24;
	localparam int        DIRECT_CNT  = 16;
	localparam int        COPY_FLAG   = 15;
	localparam logic [7:0] CFG_WORDS  = 8'h40;
	localparam logic [7:0] LUT_WORDS  = 8'hC0;
	localparam logic [7:0] ADDR_ZERO  = 8'h00;
	localparam logic [7:0] ADDR_ONE   = 8'h01;

	// Signature word
	localparam logic [7:0]  ADDR_MAGIC  = 8'h37;
	localparam logic [15:0] MAGIC_VALUE = 16'hAA55;

	// Copy ranges; the layout range 0x4C..0x4F is not walked
	localparam logic [7:0] DIRECT_FIRST = 8'h10;
	localparam logic [7:0] DIRECT_LAST  = 8'h1F;
	localparam logic [7:0] COND_FIRST   = 8'h2C;
	localparam logic [7:0] COND_LAST    = 8'h33;
	localparam logic [7:0] LAYOUT_FIRST = 8'h4C;
	localparam logic [7:0] LAYOUT_LAST  = 8'h4F;

	// Working register defaults
	localparam logic [15:0] WORK_RESET = 16'h0000;
	localparam logic [15:0] WORD_ZERO  = 16'h0000;

	// Register offsets
	localparam logic [7:0] TEMP_HIGH_THRESH_CH1    = 8'h10;
	localparam logic [7:0] TEMP_LOW_THRESH_CH1     = 8'h11;
	localparam logic [7:0] CURRENT_HIGH_THRESH_CH1 = 8'h12;
	localparam logic [7:0] CURRENT_LOW_THRESH_CH1  = 8'h13;
	localparam logic [7:0] TEMP_HIGH_THRESH_CH2    = 8'h14;
	localparam logic [7:0] TEMP_LOW_THRESH_CH2     = 8'h15;
	localparam logic [7:0] CURRENT_HIGH_THRESH_CH2 = 8'h16;
	localparam logic [7:0] CURRENT_LOW_THRESH_CH2  = 8'h17;
	localparam logic [7:0] HARDWARE_CONFIG_INIT    = 8'h18;
	localparam logic [7:0] ALARM_SOFT_CONFIG_INIT  = 8'h19;
	localparam logic [7:0] SOFT_CONFIG_INIT        = 8'h1A;
	localparam logic [7:0] ALARM_HW_CONFIG_INIT    = 8'h1B;
	localparam logic [7:0] BIAS_SETPOINT_CH1       = 8'h1C;
	localparam logic [7:0] HYST_AVG_CH1_CFG        = 8'h1D;
	localparam logic [7:0] BIAS_SETPOINT_CH2       = 8'h1E;
	localparam logic [7:0] HYST_AVG_CH2_CFG        = 8'h1F;
	localparam logic [7:0] DAC_CODE_INIT_CH1       = 8'h2C;
	localparam logic [7:0] DAC_OFFSET_INIT_CH1     = 8'h2D;
	localparam logic [7:0] DAC_CODE_INIT_CH2       = 8'h2E;
	localparam logic [7:0] DAC_OFFSET_INIT_CH2     = 8'h2F;
	localparam logic [7:0] AMP_CALIBRATION_INIT    = 8'h30;
	localparam logic [7:0] CONVERSION_CONTROL_INIT = 8'h31;
	localparam logic [7:0] SHUTDOWN_CONTROL_INIT   = 8'h32;
	localparam logic [7:0] DAC_LOAD_CONTROL_INIT   = 8'h33;
	localparam logic [7:0] MAGIC_NUMBER            = 8'h37;
	localparam logic [7:0] TEMP_TABLE_LAYOUT_CH1   = 8'h4C;
	localparam logic [7:0] POWER_TABLE_LAYOUT_CH1  = 8'h4D;
	localparam logic [7:0] TEMP_TABLE_LAYOUT_CH2   = 8'h4E;
	localparam logic [7:0] POWER_TABLE_LAYOUT_CH2  = 8'h4F;

	// Loader states
	typedef enum logic [2:0] {
		S_SIG  = 3'b001,
		S_COPY = 3'b010,
		S_DONE = 3'b100
	} load_state_t;

endpackage
`default_nettype wire

// *** logic/eeprom_powerup_config_loader.sv ***
// Nonvolatile word store, working register file and power-up loader.
// Assumes the store survives RST; a new RST models a power cycle.
// Assumes the host streams store words only with STREAM_MODE high and
// waits for LOAD_DONE before using the working registers.
// Summary of operation
// - Store holds 256 words of 16 bits
// - Low 64 config words, upper 192 tables
// - Copy only when word 0x37 is 0xAA55
// - Words 0x10..0x1F copy unconditionally
// - Words 0x2C..0x33 copy when bit 15 set
// - No signature: working registers keep defaults
// - Working writes never alter stored words
// - Valid load enables gate bias automatically
// - User words are never copied
// - Table words read as signed values
// - Store written only in streaming mode
`timescale 1ns/100ps
`default_nettype none
module eeprom_powerup_config_loader
	import loader_pkg::*;
#(
	parameter logic [15:0] RESET_VALUE = WORK_RESET
)(
	input  wire logic               CLOCK,
	input  wire logic               RST,
	input  wire logic               STREAM_MODE,
	input  wire logic               NV_WE,
	input  wire logic [7:0]         NV_WADDR,
	input  wire logic [15:0]        NV_WDATA,
	input  wire logic [7:0]         NV_RADDR,
	output logic      [15:0]        NV_RDATA,
	input  wire logic               WR_WE,
	input  wire logic [7:0]         WR_ADDR,
	input  wire logic [15:0]        WR_WDATA,
	input  wire logic [7:0]         WR_RADDR,
	output logic      [15:0]        WR_RDATA,
	input  wire logic [7:0]         LUT_INDEX,
	output logic signed [15:0]      LUT_VALUE,
	output logic                    LOAD_DONE,
	output logic                    STORE_VALID,
	output logic                    GATE_BIAS_EN
);

	// Address classes of the copy walk
	function automatic logic is_direct(input logic [7:0] a);
		return (a >= DIRECT_FIRST) && (a <= DIRECT_LAST);
	endfunction

	function automatic logic is_cond(input logic [7:0] a);
		return (a >= COND_FIRST) && (a <= COND_LAST);
	endfunction

	function automatic logic is_work(input logic [7:0] a);
		return is_direct(a) || is_cond(a);
	endfunction

	// Compact index into the working file; direct words first
	function automatic logic [4:0] work_idx(input logic [7:0] a);
		logic [7:0] d;
		d = is_direct(a) ? (a - DIRECT_FIRST)
			: (a - COND_FIRST + 8'(DIRECT_CNT));
		return d[4:0];
	endfunction

	logic [15:0]        store_mem [NV_WORDS];
	logic [15:0]        work_mem  [WORK_COUNT];
	load_state_t        state_ff;
	load_state_t        nxt_state;
	logic [7:0]         walk_ff;
	logic [7:0]         nxt_walk;
	logic               valid_ff;
	logic               done_ff;
	logic               bias_ff;
	logic [15:0]        nv_rdata_ff;
	logic [15:0]        wr_rdata_ff;
	logic signed [15:0] lut_value_ff;
	logic [4:0]         copy_cnt_ff;
	logic [4:0]         nxt_copy_cnt;

	// Decode of the walk, the signature and the write ports
	wire [15:0] walk_word = store_mem[walk_ff];
	wire [4:0]  walk_idx  = work_idx(walk_ff);
	wire [15:0] walk_old  = work_mem[walk_idx];
	wire        sig_ok    = store_mem[ADDR_MAGIC] == MAGIC_VALUE;
	wire        in_sig    = state_ff == S_SIG;
	wire        in_copy   = state_ff == S_COPY;
	wire        walk_end  = walk_ff == COND_LAST;
	wire [7:0]  walk_step = (walk_ff == DIRECT_LAST) ? COND_FIRST
				: walk_ff + ADDR_ONE;
	wire        word_ok   = is_direct(walk_ff)
				|| (is_cond(walk_ff) && walk_word[COPY_FLAG]);
	wire        copy_now  = in_copy && word_ok;
	wire        stream_wr = NV_WE && STREAM_MODE;
	wire        host_wr   = WR_WE && done_ff && is_work(WR_ADDR);
	wire [4:0]  host_idx  = work_idx(WR_ADDR);
	wire [4:0]  rd_idx    = work_idx(WR_RADDR);
	wire        rd_hit    = is_work(WR_RADDR);

	// Table reads are offset past the configuration words
	wire [7:0]  lut_addr  = LUT_INDEX + CFG_WORDS;
	wire        lut_hit   = LUT_INDEX < LUT_WORDS;
	wire [15:0] lut_word  = store_mem[lut_addr];
	wire [15:0] nv_word   = store_mem[NV_RADDR];
	wire [15:0] store_at  = store_mem[WR_ADDR];
	wire [15:0] nv_wold   = store_mem[NV_WADDR];
	wire [15:0] host_old  = work_mem[host_idx];
	wire [15:0] rd_word   = work_mem[rd_idx];

	// Loader sequence; an unknown signature also falls to done.
	// Timeline after RST falls, one store word per edge:
	//   edge 1       signature read, STORE_VALID decided
	//   edges 2-17   0x10..0x1F copied whatever they hold
	//   edges 18-25  0x2C..0x33 copied only with the top bit set
	//   edge 25      LOAD_DONE, and GATE_BIAS_EN after a good load
	// A blank store raises LOAD_DONE at edge 1 and leaves every
	// working register at RESET_VALUE.
	// Walk, host and table reads each have their own read path into
	// the store, so none waits on another; the cost is three read
	// multiplexers on the array instead of one shared port.
	always_comb begin
		nxt_state = state_ff;
		nxt_walk  = walk_ff;
		unique case (state_ff)
			S_SIG: begin
				if (sig_ok) begin
					nxt_state = S_COPY;
					nxt_walk  = DIRECT_FIRST;
				end else begin
					nxt_state = S_DONE;
				end
			end
			S_COPY: begin
				if (walk_end) begin
					nxt_state = S_DONE;
				end else begin
					nxt_walk = walk_step;
				end
			end
			S_DONE: begin
				nxt_state = S_DONE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_ff <= S_SIG;
			walk_ff  <= ADDR_ZERO;
		end else begin
			state_ff <= nxt_state;
			walk_ff  <= nxt_walk;
		end
	end

	// Status flags; bias starts with done only after a good load
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			valid_ff <= 1'b0;
			done_ff  <= 1'b0;
			bias_ff  <= 1'b0;
		end else begin
			valid_ff <= in_sig ? sig_ok : valid_ff;
			done_ff  <= nxt_state == S_DONE;
			bias_ff  <= (nxt_state == S_DONE) && valid_ff;
		end
	end

	// Copy cycles seen in this load; only the checks below read it, to
	// prove the walk neither skips nor repeats a word
	assign nxt_copy_cnt = in_copy ? copy_cnt_ff + 5'(ADDR_ONE)
		: copy_cnt_ff;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			copy_cnt_ff <= 5'(ADDR_ZERO);
		end else begin
			copy_cnt_ff <= nxt_copy_cnt;
		end
	end

	// Store keeps no reset: its contents outlive RST
	always_ff @(posedge CLOCK) begin
		if (stream_wr) begin
			store_mem[NV_WADDR] <= NV_WDATA;
		end
	end

	// Working file; host writes wait for done so the walk owns it
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			for (int i = 0; i < WORK_COUNT; i++) begin
				work_mem[i] <= RESET_VALUE;
			end
		end else if (copy_now) begin
			work_mem[walk_idx] <= walk_word;
		end else if (host_wr) begin
			work_mem[host_idx] <= WR_WDATA;
		end
	end

	// Registered read ports
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			nv_rdata_ff  <= WORD_ZERO;
			wr_rdata_ff  <= WORD_ZERO;
			lut_value_ff <= WORD_ZERO;
		end else begin
			nv_rdata_ff  <= nv_word;
			wr_rdata_ff  <= rd_hit ? work_mem[rd_idx] : WORD_ZERO;
			lut_value_ff <= lut_hit ? $signed(lut_word)
				: $signed(WORD_ZERO);
		end
	end

	// Outputs straight from flip-flops
	assign NV_RDATA     = nv_rdata_ff;
	assign WR_RDATA     = wr_rdata_ff;
	assign LUT_VALUE    = lut_value_ff;
	assign LOAD_DONE    = done_ff;
	assign STORE_VALID  = valid_ff;
	assign GATE_BIAS_EN = bias_ff;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// Signature decisions
	a_sig_reject: assert property (
		in_sig && !sig_ok |=> state_ff == S_DONE && !STORE_VALID
	) else $error("missing signature did not skip the load");

	a_sig_accept: assert property (
		in_sig && sig_ok |=> in_copy && walk_ff == DIRECT_FIRST
			&& STORE_VALID
	) else $error("signature accepted but walk not started");

	// Copy contents
	a_direct_copy: assert property (
		in_copy && is_direct(walk_ff)
		|=> work_mem[$past(walk_idx)] === $past(walk_word)
	) else $error("direct word not copied");

	a_cond_copy: assert property (
		in_copy && is_cond(walk_ff)
		|=> work_mem[$past(walk_idx)] === ($past(walk_word[COPY_FLAG])
			? $past(walk_word) : $past(walk_old))
	) else $error("conditional copy ignored its flag");

	a_user_never: assert property (
		in_copy |-> is_work(walk_ff) && walk_ff < CFG_WORDS
	) else $error("walk visited a user or table word");

	// Load takes exactly 24 words, then bias starts
	a_load_time: assert property (
		in_sig && sig_ok |=> !LOAD_DONE [*8] ##17 LOAD_DONE
			&& GATE_BIAS_EN
	) else $error("load length or bias start wrong");

	a_done_order: assert property (
		in_copy && !walk_end |=> walk_ff == $past(walk_step)
			&& !LOAD_DONE
	) else $error("walk order or early done");

	// Store isolation and store read ports
	a_store_isolated: assert property (
		WR_WE && !stream_wr |=> store_mem[$past(WR_ADDR)] === $past(store_at)
	) else $error("working write changed the store");

	a_stream_write: assert property (
		stream_wr |=> store_mem[$past(NV_WADDR)] === $past(NV_WDATA)
	) else $error("streamed word not stored");

	a_stream_gate: assert property (
		NV_WE && !STREAM_MODE
		|=> store_mem[$past(NV_WADDR)] === $past(nv_wold)
	) else $error("store written outside streaming mode");

	a_nv_read: assert property (
		1'b1 |=> NV_RDATA === $past(nv_word)
	) else $error("store read port wrong");

	a_lut_signed: assert property (
		lut_hit |=> LUT_VALUE === $signed($past(lut_word))
	) else $error("table word not returned as signed");

	a_lut_range: assert property (
		!lut_hit |=> LUT_VALUE === WORD_ZERO
	) else $error("index past the table region not read as zero");

	a_lut_offset: assert property (
		lut_hit |-> lut_addr >= CFG_WORDS
	) else $error("table read fell into the configuration words");

	// Working file port
	a_host_write: assert property (
		host_wr |=> work_mem[$past(host_idx)] === $past(WR_WDATA)
	) else $error("working write did not land");

	// Early writes would race the walk and be lost or half applied
	a_host_blocked: assert property (
		WR_WE && !done_ff && is_work(WR_ADDR)
			&& !(copy_now && walk_idx == host_idx)
		|=> work_mem[$past(host_idx)] === $past(host_old)
	) else $error("working write accepted before the load ended");

	a_wr_read: assert property (
		rd_hit |=> WR_RDATA === $past(rd_word)
	) else $error("working read port wrong");

	a_wr_unmapped: assert property (
		!rd_hit |=> WR_RDATA === WORD_ZERO
	) else $error("unmapped working address not read as zero");

	// Sequencer integrity
	a_state_onehot: assert property (
		$onehot(state_ff)
	) else $error("loader state not one-hot");

	a_walk_start: assert property (
		in_sig |-> walk_ff == ADDR_ZERO
	) else $error("walk pointer moved before the signature");

	a_walk_ascend: assert property (
		in_copy && !walk_end |=> walk_ff > $past(walk_ff)
	) else $error("walk did not ascend");

	a_done_sticky: assert property (
		LOAD_DONE |=> LOAD_DONE
	) else $error("done dropped without reset");

	a_valid_hold: assert property (
		!in_sig && STORE_VALID |=> STORE_VALID
	) else $error("signature flag dropped after the check");

	a_count_good: assert property (
		$rose(LOAD_DONE) && STORE_VALID
		|-> copy_cnt_ff == 5'(WORK_COUNT)
	) else $error("good load did not take one cycle a word");

	a_count_blank: assert property (
		$rose(LOAD_DONE) && !STORE_VALID
		|-> copy_cnt_ff == 5'(ADDR_ZERO)
	) else $error("blank store still walked the copy range");

	// Gate bias start
	a_bias_good: assert property (
		GATE_BIAS_EN |-> STORE_VALID && LOAD_DONE
	) else $error("bias started without a good load");

	a_bias_blank: assert property (
		LOAD_DONE && !STORE_VALID |-> !GATE_BIAS_EN
	) else $error("bias started after a blank store");

	a_bias_with_done: assert property (
		$rose(GATE_BIAS_EN) |-> $rose(LOAD_DONE)
	) else $error("bias did not start together with done");

	a_bias_hold: assert property (
		GATE_BIAS_EN |=> GATE_BIAS_EN
	) else $error("bias dropped without reset");

	// Main scenarios
	c_good_load: cover property (in_sig && sig_ok ##25 GATE_BIAS_EN);
	c_blank_load: cover property (in_sig && !sig_ok ##1 LOAD_DONE);
	c_flag_skip: cover property (in_copy && is_cond(walk_ff)
		&& !walk_word[COPY_FLAG]);
	c_host_write: cover property (host_wr);
	c_stream_refused: cover property (NV_WE && !STREAM_MODE);

endmodule
`default_nettype wire

// *** sim/nv_stream_host.sv ***
// Host side of the table-streaming port: writes one store word a call.
// Assumes inputs are sampled on the rising edge of CLOCK.
`timescale 1ns/100ps
`default_nettype none
module nv_stream_host (
	input  wire logic        CLOCK,
	output logic             STREAM_MODE,
	output logic             NV_WE,
	output logic [7:0]       NV_WADDR,
	output logic [15:0]      NV_WDATA
);
	// Idle with strobe and mode low
	initial begin
		STREAM_MODE = 1'b0;
		NV_WE = 1'b0;
		NV_WADDR = 8'h00;
		NV_WDATA = 16'h0000;
	end
	// Mode low makes the attempt one the device must refuse
	task automatic put(input logic [7:0] a, input logic [15:0] d,
		input logic m);
		@(posedge CLOCK);
		#5;
		STREAM_MODE = m;
		NV_WE = 1'b1;
		NV_WADDR = a;
		NV_WDATA = d;
		@(posedge CLOCK);
		#5;
		STREAM_MODE = 1'b0;
		NV_WE = 1'b0;
		NV_WADDR = ~a; // Released lines drop the old value
		NV_WDATA = ~d;
	endtask
endmodule
`default_nettype wire

// *** sim/eeprom_powerup_config_loader_tb.sv ***
// Self-checking bench for the power-up configuration loader.
// Assumes loader_pkg and nv_stream_host are compiled first.
`timescale 1ns/100ps
`default_nettype none
module eeprom_powerup_config_loader_tb;
	import loader_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        stream_mode, nv_we, wr_we = 1'b0;
	logic [7:0]  nv_waddr, nv_raddr = 8'h00, wr_addr = 8'h00;
	logic [7:0]  wr_raddr = 8'h00, lut_index = 8'h00;
	logic [15:0] nv_wdata, nv_rdata, wr_wdata = 16'h0000, wr_rdata;
	logic signed [15:0] lut_value;
	logic        load_done, store_valid, gate_bias_en;
	int          err_count = 0;
	int          checked = 0;
	logic [7:0]  ra[9] = '{8'h10, 8'h11, 8'h1F, 8'h2C, 8'h2D, 8'h32,
		8'h33, 8'h20, 8'h0F};
	logic [15:0] re[9] = '{16'h8010, 16'h0011, 16'h001F, 16'h802C,
		16'h0000, 16'h8032, 16'h0000, 16'h0000, 16'h0000};

	always #25 clock = ~clock;

	nv_stream_host host (.CLOCK(clock), .STREAM_MODE(stream_mode),
		.NV_WE(nv_we), .NV_WADDR(nv_waddr), .NV_WDATA(nv_wdata));

	eeprom_powerup_config_loader uut (.CLOCK(clock), .RST(rst),
		.STREAM_MODE(stream_mode), .NV_WE(nv_we), .NV_WADDR(nv_waddr),
		.NV_WDATA(nv_wdata), .NV_RADDR(nv_raddr), .NV_RDATA(nv_rdata),
		.WR_WE(wr_we), .WR_ADDR(wr_addr), .WR_WDATA(wr_wdata),
		.WR_RADDR(wr_raddr), .WR_RDATA(wr_rdata), .LUT_INDEX(lut_index),
		.LUT_VALUE(lut_value), .LOAD_DONE(load_done),
		.STORE_VALID(store_valid), .GATE_BIAS_EN(gate_bias_en));

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Status flags packed as valid, done, bias
	task automatic flags(input logic [15:0] e);
		chk({13'h0000, store_valid, load_done, gate_bias_en}, e);
	endtask

	// Read ports answer one edge after the address; s picks the port
	task automatic rd(input int s, input logic [7:0] a,
		input logic [15:0] e);
		@(posedge clock);
		#5;
		wr_raddr = a;
		nv_raddr = a;
		lut_index = a;
		@(posedge clock);
		#5;
		chk(s == 0 ? wr_rdata : s == 1 ? nv_rdata : lut_value, e);
	endtask

	// Working write: strobe stands for one edge, then data is spoiled
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		#5;
		wr_we = 1'b1;
		wr_addr = a;
		wr_wdata = d;
		@(posedge clock);
		#5;
		wr_we = 1'b0;
		wr_wdata = ~d;
	endtask

	// Reset held one edge models a power cycle
	task automatic pulse;
		@(posedge clock);
		#5;
		rst = 1'b1;
		@(posedge clock);
		#5;
		rst = 1'b0;
	endtask

	task automatic print_verdict;
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge clock);
		#5;
		flags(16'h0000);
		rst = 1'b0;
		// Bit 15 set on even words only, to split the flagged range
		for (int i = 15; i < 55; i++) begin
			host.put(8'(i), {~i[0], 7'h00, 8'(i)}, 1'b1);
		end
		host.put(ADDR_MAGIC, MAGIC_VALUE, 1'b1);
		host.put(8'h40, 16'hF000, 1'b1);
		host.put(8'hFF, 16'h1234, 1'b1);
		pulse();
		// Write during the walk must be refused; row 0x11 cannot show it, as the walk copies 0x11 one edge later
		wr(8'h11, 16'h5555);
		repeat (22) @(posedge clock);
		#5;
		flags(16'h0004);
		@(posedge clock);
		#5;
		flags(16'h0007);
		for (int i = 0; i < 9; i++) begin
			rd(0, ra[i], re[i]);
		end
		rd(1, 8'hFF, 16'h1234);
		rd(2, 8'h00, 16'hF000);
		rd(2, 8'hC0, 16'h0000);
		wr(8'h10, 16'h1111);
		rd(0, 8'h10, 16'h1111);
		rd(1, 8'h10, 16'h8010);
		host.put(8'h10, 16'h2222, 1'b0);
		rd(1, 8'h10, 16'h8010);
		host.put(ADDR_MAGIC, 16'hAA54, 1'b1);
		pulse();
		@(posedge clock);
		#5;
		flags(16'h0002);
		rd(0, 8'h10, 16'h0000);
		print_verdict();
	end
endmodule
`default_nettype wire
